// File: src/ext_bus_hold_handshake.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Grant waits until every pending memory transaction has completed.
// - With grant_block set, the bus is never granted however long the request stays low.
// - Bus outputs float no sooner than 4 memory periods after the request falls.
// - Grant falls after the bus floats, within 0 to 2 memory periods.
// - Bus is driven again 2 to 7 memory periods after the request rises.
// - Grant rises after the bus is driven again, within 0 to 2 memory periods.
// - The tristate select bit chooses a toggling or floating memory clock during hold.
// - A floating memory clock follows the same release and resume timing as the bus.
// - Released outputs are chip selects, byte enables, data, address, strobes, clock enable, bank-3 enable.
// - In SDRAM accesses the shared pins carry column, write and row strobes.
// - The memory period comes from the external clock or CPU clock divided by 1, 2 or 4.
module ext_bus_hold_handshake
  import bus_hold_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic extBusRequestN,
  output logic extBusGrantN,
  input wire logic grantBlock,
  input wire logic clkoutTristateSel,
  input wire bus_hold_pkg::clk_src_t clkSource,
  input wire logic memIfClockIn,
  input wire logic transactionPending,
  input wire logic sdramAccess,
  input wire logic [CHIP_SELECT_WIDTH-1:0] coreChipSelectN,
  input wire logic [BYTE_ENABLE_WIDTH-1:0] coreByteEnableN,
  input wire logic [DATA_WIDTH-1:0] coreDataOut,
  input wire logic coreDataDrive,
  input wire logic [ADDR_WIDTH-1:0] coreAddr,
  input wire logic coreReadStrobeN,
  input wire logic coreWriteStrobeN,
  input wire logic coreOutputEnN,
  input wire logic sdramColStrobeN,
  input wire logic sdramWriteStrobeN,
  input wire logic sdramRowStrobeN,
  input wire logic coreSdramClockEn,
  input wire logic coreSyncOutEnBank3N,
  input wire logic coreMemClock,
  output logic [CHIP_SELECT_WIDTH-1:0] chipSelectN,
  output logic [BYTE_ENABLE_WIDTH-1:0] byteEnableN,
  output logic [DATA_WIDTH-1:0] dataOut,
  output logic dataOe,
  output logic [ADDR_WIDTH-1:0] addrOut,
  output logic sharedReadStrobePin,
  output logic sharedWriteStrobePin,
  output logic sharedOutputEnPin,
  output logic sdramClockEn,
  output logic syncOutEnBank3N,
  output logic busOe,
  output logic memClockOut,
  output logic memClockOe,
  output logic holdActive
);
  // Gray-coded along the request, release, grant, resume path
  typedef enum logic [2:0] {
    ST_OWN     = 3'h0,
    ST_WAIT    = 3'h1,
    ST_FLOAT   = 3'h3,
    ST_GRANTED = 3'h2,
    ST_RESUME  = 3'h6,
    ST_DRIVEN  = 3'h7
  } hold_st_t;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] reqSync;
    hold_st_t st;
    logic [PERIOD_COUNT_WIDTH-1:0] periods;
    logic busDriven;
    logic grantN;
    logic [CHIP_SELECT_WIDTH-1:0] cs;
    logic [BYTE_ENABLE_WIDTH-1:0] be;
    logic [DATA_WIDTH-1:0] data;
    logic dataDrive;
    logic [ADDR_WIDTH-1:0] addr;
    logic rd;
    logic wr;
    logic oe;
    logic cke;
    logic soe3;
  } hold_state_t;

  hold_state_t state;
  hold_state_t next_state;
  logic tick;
  logic reqLow;

  // Memory period tick from selected clock source
  mem_tick_gen tickGen (
    .clock(clock),
    .reset(reset),
    .clkSource(clkSource),
    .memIfClockIn(memIfClockIn),
    .tick(tick)
  );

  // Request acted on only after the second stage
  assign reqLow = ~state.reqSync[SYNC_STAGES-1];

  // Handshake sequencing and pin registers
  always_comb begin
    next_state = state;
    next_state.reqSync = {state.reqSync[SYNC_STAGES-2:0], extBusRequestN};
    if (tick && state.periods != '1) begin
      next_state.periods = state.periods + 4'h1;
    end
    case (state.st)
      ST_OWN: begin
        next_state.periods = '0;
        if (reqLow) begin
          next_state.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Blocked grant just waits; master's request stays low
        if (!reqLow) begin
          next_state.st = ST_OWN;
        end else if (!transactionPending && !grantBlock
            && state.periods >= 4'(RELEASE_MIN_PERIODS)) begin
          next_state.st = ST_FLOAT;
          next_state.busDriven = 1'b0;
          next_state.periods = '0;
        end
      end
      ST_FLOAT: begin
        // One period after floating, within the 2-period window
        if (state.periods >= 4'h1) begin
          next_state.grantN = 1'b0;
          next_state.st = ST_GRANTED;
        end
      end
      ST_GRANTED: begin
        next_state.periods = '0;
        if (!reqLow) begin
          next_state.st = ST_RESUME;
        end
      end
      ST_RESUME: begin
        // Sync latency plus 3 periods stays inside 2..7
        if (state.periods >= 4'(RESUME_MIN_PERIODS + 1)) begin
          next_state.busDriven = 1'b1;
          next_state.periods = '0;
          next_state.st = ST_DRIVEN;
        end
      end
      ST_DRIVEN: begin
        if (state.periods >= 4'h1) begin
          next_state.grantN = 1'b1;
          next_state.st = ST_OWN;
        end
      end
      default: next_state.st = ST_OWN;
    endcase
    // Registered pin values; strobe pins take SDRAM roles when asked
    next_state.cs = coreChipSelectN;
    next_state.be = coreByteEnableN;
    next_state.data = coreDataOut;
    next_state.dataDrive = coreDataDrive;
    next_state.addr = coreAddr;
    next_state.rd = sdramAccess ? sdramColStrobeN : coreReadStrobeN;
    next_state.wr = sdramAccess ? sdramWriteStrobeN : coreWriteStrobeN;
    next_state.oe = sdramAccess ? sdramRowStrobeN : coreOutputEnN;
    next_state.cke = coreSdramClockEn;
    next_state.soe3 = coreSyncOutEnBank3N;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '0;
      state.reqSync <= '1;
      state.st <= ST_OWN;
      state.busDriven <= 1'b1;
      state.grantN <= GRANT_RESET;
      state.cs <= '1;
      state.be <= '1;
      state.rd <= 1'b1;
      state.wr <= 1'b1;
      state.oe <= 1'b1;
      state.soe3 <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Released group shares one enable
  assign chipSelectN = state.cs;
  assign byteEnableN = state.be;
  assign dataOut = state.data;
  assign dataOe = state.dataDrive & state.busDriven;
  assign addrOut = state.addr;
  assign sharedReadStrobePin = state.rd;
  assign sharedWriteStrobePin = state.wr;
  assign sharedOutputEnPin = state.oe;
  assign sdramClockEn = state.cke;
  assign syncOutEnBank3N = state.soe3;
  assign busOe = state.busDriven;
  assign extBusGrantN = state.grantN;
  assign holdActive = ~state.grantN;
  // Clock keeps toggling unless selected to float
  assign memClockOut = coreMemClock;
  assign memClockOe = state.busDriven | ~clkoutTristateSel;
endmodule
`default_nettype wire

// File: common/bus_hold_pkg.sv
package bus_hold_pkg;
  // Memory-interface clock source selections
  typedef enum logic [1:0] {
    SRC_EXT_CLK  = 2'h0,
    SRC_CPU_DIV1 = 2'h1,
    SRC_CPU_DIV2 = 2'h2,
    SRC_CPU_DIV4 = 2'h3
  } clk_src_t;

  // Hold timing in memory-interface clock periods
  localparam int RELEASE_MIN_PERIODS = 4;
  localparam int GRANT_LAG_MAX_PERIODS = 2;
  localparam int RESUME_MIN_PERIODS = 2;
  localparam int RESUME_MAX_PERIODS = 7;
  localparam int SYNC_STAGES = 2;
  localparam int PERIOD_COUNT_WIDTH = 4;

  // Pin group widths
  localparam int CHIP_SELECT_WIDTH = 4;
  localparam int BYTE_ENABLE_WIDTH = 4;
  localparam int DATA_WIDTH = 32;
  localparam int ADDR_MSB = 21;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_WIDTH = ADDR_MSB - ADDR_LSB + 1;

  // Reset values
  localparam logic GRANT_RESET = 1'b1;
  localparam logic [1:0] DIV_RESET = 2'h0;
endpackage

// File: src/mem_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Produces one tick per memory-interface clock period
module mem_tick_gen
  import bus_hold_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire bus_hold_pkg::clk_src_t clkSource,
  input wire logic memIfClockIn,
  output logic tick
);
  typedef struct packed {
    logic [1:0] div;
    logic [SYNC_STAGES-1:0] extSync;
    logic extLast;
  } tick_state_t;

  tick_state_t state;
  tick_state_t next_state;
  logic extRise;

  // Only the second sync stage feeds the edge detector
  assign extRise = state.extSync[1] & ~state.extLast;

  // Divider and external clock edge tracking
  always_comb begin
    next_state = state;
    next_state.div = state.div + 2'h1;
    next_state.extSync = {state.extSync[0], memIfClockIn};
    next_state.extLast = state.extSync[1];
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Select period source
  always_comb begin
    case (clkSource)
      SRC_EXT_CLK: tick = extRise;
      SRC_CPU_DIV1: tick = 1'b1;
      SRC_CPU_DIV2: tick = state.div[0];
      SRC_CPU_DIV4: tick = (state.div == 2'h3);
      default: tick = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// File: test/hold_handshake_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hold_handshake_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic extBusRequestN,
  input wire logic extBusGrantN,
  input wire logic grantBlock,
  input wire logic transactionPending,
  input wire logic clkoutTristateSel,
  input wire logic busOe,
  input wire logic memClockOe
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Three cycles of a pending transfer means no release now
  property p_pending_waits; transactionPending[*3] |-> !$fell(busOe); endproperty
  a_pending_waits: assert property (p_pending_waits) else $error("floated mid transfer");
  property p_block_waits; grantBlock[*3] |-> !$fell(busOe); endproperty
  a_block_waits: assert property (p_block_waits) else $error("floated while blocked");
  property p_release_min; $fell(extBusRequestN) && busOe |-> busOe[*4]; endproperty
  a_release_min: assert property (p_release_min) else $error("bus floated early");
  property p_grant_order; $fell(extBusGrantN) |-> !busOe; endproperty
  a_grant_order: assert property (p_grant_order) else $error("grant before float");
  property p_grant_lag; $fell(busOe) |-> ##[0:2] !extBusGrantN; endproperty
  a_grant_lag: assert property (p_grant_lag) else $error("grant late");
  property p_resume; $rose(extBusRequestN) && !busOe |-> !busOe ##1 !busOe ##[1:6] busOe;
  endproperty
  a_resume: assert property (p_resume) else $error("resume out of window");
  property p_ungrant_order; $rose(extBusGrantN) |-> busOe; endproperty
  a_ungrant_order: assert property (p_ungrant_order) else $error("ungrant while floating");
  property p_ungrant_lag; $rose(busOe) |-> ##[0:2] extBusGrantN; endproperty
  a_ungrant_lag: assert property (p_ungrant_lag) else $error("ungrant late");
  property p_clock_float; memClockOe == (busOe || !clkoutTristateSel); endproperty
  a_clock_float: assert property (p_clock_float) else $error("clock drive wrong");
endmodule
bind ext_bus_hold_handshake hold_handshake_monitor mon (.clock, .reset, .extBusRequestN,
  .extBusGrantN, .grantBlock, .transactionPending, .clkoutTristateSel, .busOe, .memClockOe);
`default_nettype wire

// File: test/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input wire logic clock,
  input wire logic start,
  input wire logic stay,
  input wire logic grantN,
  output logic reqN
);
  initial reqN = 1'b1;
  // Request held until grant seen low; stay makes the master slow to let go
  always @(posedge clock) begin
    if (start) reqN <= #1 1'b0;
    else if (!grantN && !stay) reqN <= #1 1'b1;
  end
endmodule
`default_nettype wire

// File: test/ext_bus_hold_handshake_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module ext_bus_hold_handshake_tb;
  import bus_hold_pkg::*;
  logic clock = 1'b0, reset = 1'b1, start = 1'b0, stay = 1'b1;
  logic [3:0] csOut, beOut;
  logic [19:0] addrOut;
  logic ckeOut, soe3Out, memClk, holdAct;
  logic grantBlock = 1'b0, pending = 1'b0, clkSel = 1'b1;
  logic [6:0] s = 7'h7F;
  logic [31:0] pat = 32'h0;
  logic reqN, grantN, busOe, dataOe, memClockOe, rdPin, wrPin, oePin;
  logic [31:0] dataOut;
  int errors = 0, check_count = 0, n;
  // Rows: sdram select, core strobes, sdram strobes, expected pins
  logic [9:0] rows [4] = '{10'h336, 10'h071, 10'h309, 10'h0F3};
  always #2 clock = ~clock;
  bus_master_model master (.clock(clock), .start(start), .stay(stay),
    .grantN(grantN), .reqN(reqN));
  ext_bus_hold_handshake dut (.clock(clock), .reset(reset), .extBusRequestN(reqN),
    .extBusGrantN(grantN), .grantBlock(grantBlock), .clkoutTristateSel(clkSel),
    .clkSource(SRC_CPU_DIV1), .memIfClockIn(1'b0), .transactionPending(pending),
    .sdramAccess(s[6]), .coreChipSelectN(pat[3:0]), .coreByteEnableN(pat[7:4]),
    .coreDataOut(pat), .coreDataDrive(pat[8]), .coreAddr(pat[19:0]),
    .coreReadStrobeN(s[5]), .coreWriteStrobeN(s[4]), .coreOutputEnN(s[3]),
    .sdramColStrobeN(s[2]), .sdramWriteStrobeN(s[1]), .sdramRowStrobeN(s[0]),
    .coreSdramClockEn(pat[9]), .coreSyncOutEnBank3N(pat[10]), .coreMemClock(pat[11]),
    .chipSelectN(csOut), .byteEnableN(beOut), .dataOut(dataOut), .dataOe(dataOe),
    .addrOut(addrOut),
    .sharedReadStrobePin(rdPin), .sharedWriteStrobePin(wrPin), .sharedOutputEnPin(oePin),
    .sdramClockEn(ckeOut), .syncOutEnBank3N(soe3Out), .busOe(busOe), .memClockOut(memClk),
    .memClockOe(memClockOe), .holdActive(holdAct));
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bounded wait; n gives the cycles taken
  task automatic wait_lvl(ref logic sig, input logic val);
    n = 0;
    while (sig !== val && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    // A wait that runs out is a mismatch
    if (sig !== val) errors++;
  endtask
  task automatic req_go;
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
  endtask
  // Full grant and give-back, clock output floating or toggling
  task automatic hold_cycle(input logic sel);
    clkSel = sel;
    stay = 1'b1;
    req_go();
    wait_lvl(busOe, 1'b0);
    `CHK(n >= 4, 1'b1)
    wait_lvl(grantN, 1'b0);
    `CHK(n <= 2, 1'b1)
    `CHK({dataOe, memClockOe}, {1'b0, !sel})
    `CHK(holdAct, 1'b1)
    stay = 1'b0;
    wait_lvl(busOe, 1'b1);
    `CHK(n >= 2 && n <= 8, 1'b1)
    wait_lvl(grantN, 1'b1);
    `CHK(n <= 2, 1'b1)
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1 reset = 1'b0;
    `CHK({grantN, busOe}, 2'b11)
    for (int i = 0; i < 4; i++) begin
      s = rows[i][9:3];
      pat = 32'hA5C3_0100 + 32'(i);
      @(posedge clock);
      #1;
      `CHK({rdPin, wrPin, oePin}, rows[i][2:0])
      `CHK(dataOut, pat)
      `CHK({soe3Out, ckeOut, addrOut, beOut, csOut}, {pat[10:9], pat[19:0], pat[7:0]})
      `CHK(memClk, pat[11])
    end
    hold_cycle(1'b1);
    hold_cycle(1'b0);
    // Transfer in flight delays the grant until it ends
    pending = 1'b1;
    req_go();
    repeat (20) @(posedge clock);
    #1 `CHK(grantN, 1'b1)
    pending = 1'b0;
    wait_lvl(grantN, 1'b0);
    `CHK(grantN, 1'b0)
    stay = 1'b0;
    wait_lvl(grantN, 1'b1);
    // Blocked grant, given once the block clears; master keeps asking
    grantBlock = 1'b1;
    stay = 1'b1;
    req_go();
    repeat (20) @(posedge clock);
    #1 `CHK(grantN, 1'b1)
    grantBlock = 1'b0;
    wait_lvl(grantN, 1'b0);
    `CHK(grantN, 1'b0)
    stay = 1'b0;
    wait_lvl(grantN, 1'b1);
    `CHK({grantN, busOe}, 2'b11)
    print_verdict();
  end
  // Watchdog far beyond the expected run length
  initial begin
    #4000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
